// ### core/hdg_pkg.sv
// constants and helpers for the host data pin general-purpose i/o block
// ----------------------------------------------------------------------------
// Behaviour
// RQ1: gpio only when port off or wide mode
// RQ2: direction register bits 7..0, reserved above, reset 0
// RQ3: level register bits 7..0, reserved above, reset 0
// RQ4: direction at 003ch, level at 003dh
// RQ5: direction 1 drives level bit, 0 samples pin
// ----------------------------------------------------------------------------
package hdg_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int HDG_ADDR_W = 16;
  localparam int HDG_DATA_W = 16;
  localparam int HDG_PIN_N = 8;
  localparam int HDG_FIELD_LSB = 0;
  localparam int HDG_FIELD_MSB = 7;
  localparam int HDG_RSVD_LSB = 8;
  localparam int HDG_RSVD_MSB = 15;

  // --------------------------------------------------------------------------
  // memory-mapped addresses in data space
  // --------------------------------------------------------------------------
  localparam logic [15:0] HDG_DIR_ADDR = 16'h003c;
  localparam logic [15:0] HDG_LEVEL_ADDR = 16'h003d;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] HDG_DIR_RST = 8'h00;
  localparam logic [7:0] HDG_LEVEL_RST = 8'h00;
  localparam logic [7:0] HDG_RSVD_VAL = 8'h00;
  localparam logic [15:0] HDG_RDATA_RST = 16'h0000;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic hdg_hit(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction : hdg_hit

  // output pins show the level bit, input pins show the sampled pin
  function automatic logic [7:0] hdg_mix(input logic [7:0] dir, input logic [7:0] lvl,
                                         input logic [7:0] pin);
    return (dir & lvl) | (~dir & pin);
  endfunction : hdg_mix

endpackage : hdg_pkg

// ### core/hdg_pin_if.sv
// signals between the register file and the pin stage
`timescale 1ns/1ps
interface hdg_pin_if;
  logic [7:0] dir;
  logic [7:0] level;
  logic allowed;
  logic [7:0] sampled;

  modport regs (output dir, output level, output allowed, input sampled);
  modport pins (input dir, input level, input allowed, output sampled);
endinterface : hdg_pin_if

// ### core/hdg_pins.sv
// pin stage: input synchroniser and registered pin drive
`timescale 1ns/1ps
module hdg_pins
  import hdg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] pins_in,
  hdg_pin_if.pins pif,
  output logic [7:0] pins_out,
  output logic [7:0] pins_oe
);

  // --------------------------------------------------------------------------
  // synchroniser
  // --------------------------------------------------------------------------
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] oe_nxt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= HDG_LEVEL_RST;
      sync2_r <= HDG_LEVEL_RST;
    end else if (ce) begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  assign pif.sampled = sync2_r; // see RQ5

  // --------------------------------------------------------------------------
  // drive
  // --------------------------------------------------------------------------
  // while the host port owns the pins we never drive them
  assign oe_nxt = pif.allowed ? pif.dir : 8'h00; // see RQ1 see RQ5

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pins_oe <= HDG_DIR_RST;
      pins_out <= HDG_LEVEL_RST;
    end else if (ce) begin
      pins_oe <= oe_nxt;
      pins_out <= pif.level; // see RQ5
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_blocked_no_drive: assert property (@(posedge clock) disable iff (!rstn) // see RQ1
    (ce && !pif.allowed) |=> (pins_oe == 8'h00))
    else $error("pins driven while host port owns them");

  a_oe_follows_dir: assert property (@(posedge clock) disable iff (!rstn) // see RQ5
    (ce && pif.allowed) |=> (pins_oe == $past(pif.dir)))
    else $error("output enable does not follow direction");

  a_sync_two_stage: assert property (@(posedge clock) disable iff (!rstn) // see RQ5
    (ce ##1 ce) |=> (pif.sampled == $past(pins_in, 2)))
    else $error("sampled pin not two stages behind pin");

endmodule : hdg_pins

// ### core/hdg_top.sv
// host data pin general-purpose i/o: registers, decode and pin stage
`timescale 1ns/1ps
module hdg_top
  import hdg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [15:0] mm_addr,
  input wire logic mm_wr,
  input wire logic mm_rd,
  input wire logic [15:0] mm_wdata,
  output logic [15:0] mm_rdata,
  output logic mm_rvalid,
  input wire logic host_port_enable_flag,
  input wire logic host_port_wide_mode_flag,
  input wire logic [7:0] host_data_pins_in,
  output logic [7:0] host_data_pins_out,
  output logic [7:0] host_data_pins_oe,
  output logic gpio_active
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0] pin_direction_control_r;
  logic [7:0] pin_direction_control_nxt;
  logic [7:0] pin_level_status_r;
  logic [7:0] pin_level_status_nxt;
  logic [15:0] rdata_nxt;

  hdg_pin_if pif ();

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire dir_hit;
  wire level_hit;
  wire dir_wr;
  wire level_wr;
  wire allowed;
  wire [7:0] level_view;
  wire [7:0] wfield;

  assign dir_hit = hdg_hit(mm_addr, HDG_DIR_ADDR); // see RQ4
  assign level_hit = hdg_hit(mm_addr, HDG_LEVEL_ADDR); // see RQ4
  assign dir_wr = mm_wr && dir_hit;
  assign level_wr = mm_wr && level_hit;
  // reserved upper bits of a write are dropped
  assign wfield = mm_wdata[HDG_FIELD_MSB:HDG_FIELD_LSB]; // see RQ2 see RQ3

  // the flags come from host port logic on this clock, so no synchroniser
  assign allowed = !host_port_enable_flag || host_port_wide_mode_flag; // see RQ1

  assign level_view = hdg_mix(pin_direction_control_r, pin_level_status_r,
                              pif.sampled); // see RQ3 see RQ5

  assign pin_direction_control_nxt = dir_wr ? wfield : pin_direction_control_r;
  assign pin_level_status_nxt = level_wr ? wfield : pin_level_status_r;

  // unmapped reads answer zero; reserved bits always read zero
  assign rdata_nxt = !mm_rd ? mm_rdata :
                     dir_hit ? {HDG_RSVD_VAL, pin_direction_control_r} :
                     level_hit ? {HDG_RSVD_VAL, level_view} :
                     HDG_RDATA_RST; // see RQ2 see RQ3

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_direction_control_r <= HDG_DIR_RST; // see RQ2
      pin_level_status_r <= HDG_LEVEL_RST; // see RQ3
    end else if (ce) begin
      pin_direction_control_r <= pin_direction_control_nxt;
      pin_level_status_r <= pin_level_status_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mm_rdata <= HDG_RDATA_RST;
      mm_rvalid <= 1'b0;
      gpio_active <= 1'b0;
    end else if (ce) begin
      mm_rdata <= rdata_nxt;
      mm_rvalid <= mm_rd;
      gpio_active <= allowed; // see RQ1
    end
  end

  // --------------------------------------------------------------------------
  // pin stage
  // --------------------------------------------------------------------------
  assign pif.dir = pin_direction_control_r;
  assign pif.level = pin_level_status_r;
  assign pif.allowed = allowed;

  hdg_pins u_pins (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .pins_in(host_data_pins_in),
    .pif(pif),
    .pins_out(host_data_pins_out),
    .pins_oe(host_data_pins_oe)
  );

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_dir_write;
    ce && mm_wr && (mm_addr == HDG_DIR_ADDR);
  endsequence

  sequence s_level_write;
    ce && mm_wr && (mm_addr == HDG_LEVEL_ADDR);
  endsequence

  sequence s_quiet_cycle;
    ce && !mm_wr;
  endsequence

  a_dir_write_store: assert property (@(posedge clock) disable iff (!rstn) // see RQ2
    s_dir_write |=> (pin_direction_control_r == $past(mm_wdata[7:0])))
    else $error("direction write not stored");

  a_level_write_store: assert property (@(posedge clock) disable iff (!rstn) // see RQ3
    s_level_write |=> (pin_level_status_r == $past(mm_wdata[7:0])))
    else $error("level write not stored");

  a_dir_reaches_pin: assert property (@(posedge clock) disable iff (!rstn) // see RQ5
    (s_dir_write ##1 (s_quiet_cycle and allowed))
      |=> (host_data_pins_oe == $past(mm_wdata[7:0], 2)))
    else $error("direction write did not reach output enable in two cycles");

  a_level_reaches_pin: assert property (@(posedge clock) disable iff (!rstn) // see RQ5
    (s_level_write ##1 s_quiet_cycle)
      |=> (host_data_pins_out == $past(mm_wdata[7:0], 2)))
    else $error("level write did not reach pin in two cycles");

  a_dir_read_back: assert property (@(posedge clock) disable iff (!rstn) // see RQ4
    (ce && mm_rd && (mm_addr == HDG_DIR_ADDR))
      |=> (mm_rvalid && mm_rdata == {8'h00, $past(pin_direction_control_r)}))
    else $error("direction read returns wrong data");

  a_level_read_mix: assert property (@(posedge clock) disable iff (!rstn) // see RQ3 see RQ5
    (ce && mm_rd && (mm_addr == HDG_LEVEL_ADDR))
      |=> (mm_rdata[15:8] == 8'h00 &&
           mm_rdata[7:0] == (($past(pin_direction_control_r) & $past(pin_level_status_r))
                            | (~$past(pin_direction_control_r) & $past(pif.sampled)))))
    else $error("level read does not mix outputs and sampled inputs");

  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn) // see RQ4
    (ce && mm_rd && mm_addr != HDG_DIR_ADDR && mm_addr != HDG_LEVEL_ADDR)
      |=> (mm_rvalid && mm_rdata == 16'h0000))
    else $error("unmapped read not zero");

  a_gate_blocks_oe: assert property (@(posedge clock) disable iff (!rstn) // see RQ1
    (ce && host_port_enable_flag && !host_port_wide_mode_flag)
      |=> (host_data_pins_oe == 8'h00 && !gpio_active))
    else $error("pins driven while host port is enabled in narrow mode");

  a_freeze_hold: assert property (@(posedge clock) disable iff (!rstn)
    !ce |=> ($stable(pin_direction_control_r) && $stable(pin_level_status_r)
             && $stable(mm_rdata) && $stable(host_data_pins_oe)))
    else $error("state moved while clock enable low");

endmodule : hdg_top

// ### dv/hdg_ext_circuit.sv
// model of the external circuits wired to the eight host data pins
`timescale 1ns/1ps
module hdg_ext_circuit (
  input wire logic [7:0] ext_drive,
  input wire logic [7:0] pins_out,
  input wire logic [7:0] pins_oe,
  output logic [7:0] pins_in
);
  // the block wins a pin wherever it drives, the circuit holds the rest
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_drive);
endmodule : hdg_ext_circuit

// ### dv/tb.sv
// self-checking bench for the host data pin general-purpose i/o block
`timescale 1ns/1ps
module tb
  import hdg_pkg::*;
;
  // --------------------------------------------------------------------------
  // signals and instances
  // --------------------------------------------------------------------------
  logic clock, rstn, ce, mm_wr, mm_rd, en, wide, gpio_active, mm_rvalid;
  logic [15:0] mm_addr, mm_wdata, mm_rdata;
  logic [7:0] pins_in, pins_out, pins_oe, ext;
  int fail_count, num_checks, cycles, seed, dir_m, lvl_m, i;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  hdg_top dut (.clock(clock), .rstn(rstn), .ce(ce), .mm_addr(mm_addr), .mm_wr(mm_wr),
    .mm_rd(mm_rd), .mm_wdata(mm_wdata), .mm_rdata(mm_rdata), .mm_rvalid(mm_rvalid),
    .host_port_enable_flag(en), .host_port_wide_mode_flag(wide),
    .host_data_pins_in(pins_in), .host_data_pins_out(pins_out),
    .host_data_pins_oe(pins_oe), .gpio_active(gpio_active));
  hdg_ext_circuit ext_i (.ext_drive(ext), .pins_out(pins_out), .pins_oe(pins_oe),
    .pins_in(pins_in));

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    mm_addr = a;
    mm_wdata = d;
    mm_wr = 1'b1;
    @(negedge clock);
    mm_wr = 1'b0;
  endtask : wr

  task rdc(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clock);
    mm_addr = a;
    mm_rd = 1'b1;
    @(negedge clock);
    mm_rd = 1'b0;
    chk({15'h0000, mm_rvalid}, 16'h0001);
    chk(mm_rdata, exp);
  endtask : rdc

  // two synchroniser flops plus the registered pin stage must land first
  task settle;
    repeat (3) @(negedge clock);
  endtask : settle

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    seed = 59;
    {ce, rstn, mm_wr, mm_rd, en, wide} = 6'h20;
    mm_addr = 16'h0000;
    mm_wdata = 16'h0000;
    ext = 8'h5a;
    repeat (5) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    rdc(HDG_DIR_ADDR, HDG_RDATA_RST);
    rdc(HDG_LEVEL_ADDR, {8'h00, ext});
    chk({pins_oe, pins_out}, 16'h0000);
    wr(HDG_DIR_ADDR, 16'hffff);
    for (i = 0; i < 4; i++) begin
      en = i[0];
      wide = i[1];
      settle;
      chk({15'h0000, gpio_active}, {15'h0000, !en || wide});
      chk({8'h00, pins_oe}, (!en || wide) ? 16'h00ff : 16'h0000);
    end
    en = 1'b0;
    wide = 1'b0;
    for (i = 0; i < 40; i++) begin
      dir_m = $random(seed) & 255;
      lvl_m = $random(seed) & 255;
      ext = 8'($random(seed));
      wr(HDG_DIR_ADDR, 16'hff00 | dir_m[15:0]);
      wr(HDG_LEVEL_ADDR, 16'hff00 | lvl_m[15:0]);
      settle;
      rdc(HDG_DIR_ADDR, dir_m[15:0]);
      rdc(HDG_LEVEL_ADDR, 16'(((dir_m & lvl_m) | (~dir_m & ext)) & 255));
      chk({pins_oe, pins_out}, {dir_m[7:0], lvl_m[7:0]});
    end
    wr(16'h003e, 16'h00a5);
    rdc(16'h003e, 16'h0000);
    rdc(HDG_DIR_ADDR, dir_m[15:0]);
    ce = 1'b0;
    wr(HDG_DIR_ADDR, 16'(~dir_m & 255));
    ce = 1'b1;
    rdc(HDG_DIR_ADDR, dir_m[15:0]);
    rstn = 1'b0;
    @(negedge clock);
    chk({pins_oe, pins_out}, 16'h0000);
    chk(mm_rdata, HDG_RDATA_RST);
    chk({14'h0000, gpio_active, mm_rvalid}, 16'h0000);
    rstn = 1'b1;
    ext = 8'h00;
    settle;
    rdc(HDG_DIR_ADDR, HDG_RDATA_RST);
    rdc(HDG_LEVEL_ADDR, HDG_RDATA_RST);
    conclude();
  end
endmodule : tb
